// File: logic/bcr_bridge_control.sv
// Bridge control and interrupt pin configuration registers with their side effects
`timescale 1ns/10ps
`default_nettype none
module bcr_bridge_control
    import bcr_pkg::*;
#(
    parameter int DISC_LONG_CYCLES = bcr_pkg::BCR_DISC_LONG_CYC
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Configuration access, one dword per request
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [5:0]  cfg_dword,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_hit,
    // Internal reset from the diagnostic register
    input  wire logic        diag_reset_req,
    // Command register SERR enable
    input  wire logic        cmd_serr_en,
    // Delayed completion events
    input  wire logic        pri_cpl_ready,
    input  wire logic        pri_repeat,
    input  wire logic        sec_cpl_ready,
    input  wire logic        sec_repeat,
    output logic             pri_cpl_discard,
    output logic             sec_cpl_discard,
    // Master abort handling
    input  wire logic        ma_event,
    input  wire logic        ma_is_read,
    input  wire logic        ma_posted_done,
    output logic             ma_return_ones,
    output logic [31:0]      ma_read_data,
    output logic             ma_discard_write,
    output logic             ma_target_abort,
    // System error and secondary reset
    output logic             primary_system_error_out,
    output logic             sec_bus_reset_out,
    // VGA decode
    input  wire logic        fwd_valid,
    input  wire logic        fwd_from_primary,
    input  wire logic        fwd_is_io,
    input  wire logic [31:0] fwd_addr,
    output logic             vga_fwd_claim,
    output logic             vga_fwd_block,
    // Remaining control bits for other logic
    output logic             isa_en,
    output logic             sec_serr_fwd_en,
    output logic             sec_perr_en
);
    import bcr_pkg::*;

    bcr_tmr_if pri_tif ();
    bcr_tmr_if sec_tif ();

    logic [15:0] ctrl_q, ctrl_d;
    logic [31:0] rdata_q, rdata_d;
    logic        serr_q, serr_d;
    logic        ones_q, ones_d;
    logic        disc_q, disc_d;
    logic        tabort_q, tabort_d;
    logic        claim_q, claim_d;
    logic        block_q, block_d;
    logic [15:0] ctrl_rd;
    logic [15:0] wr_data;
    logic [15:0] wr_mask;
    logic        ctrl_wr;
    logic        vga_mem;
    logic        vga_io;
    logic        vga_hit;

    bcr_discard_timer #(
        .LONG_CYCLES (DISC_LONG_CYCLES)
    ) u_pri_timer (
        .clock (clock),
        .rst   (rst),
        .tif   (pri_tif.timer)
    );

    bcr_discard_timer #(
        .LONG_CYCLES (DISC_LONG_CYCLES)
    ) u_sec_timer (
        .clock (clock),
        .rst   (rst),
        .tif   (sec_tif.timer)
    );

    assign pri_tif.start     = pri_cpl_ready;
    assign pri_tif.stop      = pri_repeat;
    assign pri_tif.short_sel = ctrl_q[BCR_B_PRI_SHORT];
    assign sec_tif.start     = sec_cpl_ready;
    assign sec_tif.stop      = sec_repeat;
    assign sec_tif.short_sel = ctrl_q[BCR_B_SEC_SHORT];

    // Register state and configuration reads
    always_comb begin
        ctrl_wr = cfg_wr && (cfg_dword == BCR_DW_INTR_CTRL);
        wr_data = cfg_wdata[31:16];
        wr_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}} & BCR_CTRL_WR_MASK;
        ctrl_d  = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = (ctrl_q & ~wr_mask) | (wr_data & wr_mask);
            // Status bit ignores the plain store: one clears, zero keeps
            ctrl_d[BCR_B_DISC_STS] = ctrl_q[BCR_B_DISC_STS]
                & ~(wr_mask[BCR_B_DISC_STS] & wr_data[BCR_B_DISC_STS]);
        end
        // Expiry beats a clear in the same cycle
        if (pri_tif.expired || sec_tif.expired) begin
            ctrl_d[BCR_B_DISC_STS] = 1'b1;
        end
        if (diag_reset_req) begin
            // Internal reset clears all but forces secondary reset on
            ctrl_d                 = BCR_CTRL_RESET;
            ctrl_d[BCR_B_SEC_RST]  = 1'b1;
        end
        ctrl_rd = ctrl_q & BCR_CTRL_WR_MASK;
        rdata_d = rdata_q;
        if (cfg_rd) begin
            rdata_d = '0;
            if (cfg_dword == BCR_DW_INTR_CTRL) begin
                rdata_d = {ctrl_rd, BCR_INTR_PIN_VAL, 8'h00};
            end
        end
    end

    // Master abort, system error and VGA decode
    always_comb begin
        ones_d   = 1'b0;
        disc_d   = 1'b0;
        tabort_d = 1'b0;
        serr_d   = 1'b0;
        if (ma_event) begin
            if (!ctrl_q[BCR_B_MA_MODE]) begin
                ones_d = ma_is_read;
                disc_d = !ma_is_read;
            end else if (ma_posted_done) begin
                serr_d = cmd_serr_en;
            end else begin
                tabort_d = 1'b1;
            end
        end
        if (pri_tif.expired && ctrl_q[BCR_B_DISC_SERR]) begin
            serr_d = 1'b1;
        end
        vga_mem = !fwd_is_io && (fwd_addr >= BCR_VGA_MEM_LO)
            && (fwd_addr <= BCR_VGA_MEM_HI);
        vga_io  = fwd_is_io && (((fwd_addr >= BCR_VGA_IO1_LO) && (fwd_addr <= BCR_VGA_IO1_HI))
            || ((fwd_addr >= BCR_VGA_IO2_LO) && (fwd_addr <= BCR_VGA_IO2_HI)));
        // Decided apart from any window or ISA setting
        vga_hit = fwd_valid && ctrl_q[BCR_B_VGA_EN] && (vga_mem || vga_io);
        claim_d = vga_hit && fwd_from_primary;
        block_d = vga_hit && !fwd_from_primary;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_q   <= BCR_CTRL_RESET;
            rdata_q  <= '0;
            serr_q   <= 1'b0;
            ones_q   <= 1'b0;
            disc_q   <= 1'b0;
            tabort_q <= 1'b0;
            claim_q  <= 1'b0;
            block_q  <= 1'b0;
        end else begin
            ctrl_q   <= ctrl_d;
            rdata_q  <= rdata_d;
            serr_q   <= serr_d;
            ones_q   <= ones_d;
            disc_q   <= disc_d;
            tabort_q <= tabort_d;
            claim_q  <= claim_d;
            block_q  <= block_d;
        end
    end

    assign cfg_rdata                = rdata_q;
    assign cfg_hit                  = cfg_dword == BCR_DW_INTR_CTRL;
    assign pri_cpl_discard          = pri_tif.expired;
    assign sec_cpl_discard          = sec_tif.expired;
    assign ma_return_ones           = ones_q;
    assign ma_read_data             = ones_q ? BCR_MA_READ_VAL : 32'h0000_0000;
    assign ma_discard_write         = disc_q;
    assign ma_target_abort          = tabort_q;
    assign primary_system_error_out = serr_q;
    assign sec_bus_reset_out        = ctrl_q[BCR_B_SEC_RST];
    assign vga_fwd_claim            = claim_q;
    assign vga_fwd_block            = block_q;
    assign isa_en                   = ctrl_q[BCR_B_ISA_EN];
    assign sec_serr_fwd_en          = ctrl_q[BCR_B_SERR_EN];
    assign sec_perr_en              = ctrl_q[BCR_B_PERR_EN];
endmodule
`default_nettype wire

// File: logic/bcr_pkg.sv
// Constants and types for the bridge control register logic
//
// Function
// - Interrupt pin byte always reads zero.
// - Bridge control bits 15-12 read zero.
// - Bit 11 set lets primary discard expiry raise the system error output.
// - Discard status bit stays set; only writing one or an internal reset clears it.
// - Either discard timer expiring sets the discard status bit.
// - Secondary discard timer counts 2^15 clocks, or 2^10 with bit 9 set.
// - Primary discard timer counts 2^15 clocks, or 2^10 with bit 8 set.
// - No fast back-to-back to different targets; bit 7 reads zero.
// - Bit 6 holds secondary reset output asserted until written back to zero.
// - Mode zero: master abort returns all ones on reads, discards writes.
// - Mode one, SERR enabled, posted write completed: assert system error output.
// - Mode one, transaction not completed: answer originator with target abort.
// - Bit 4 reads zero and ignores writes.
// - VGA enable decodes frame buffer memory range, forwards primary to secondary.
// - VGA enable decodes the two legacy VGA port ranges downstream.
// - VGA enable blocks upstream forwarding of VGA memory and I/O addresses.
// - VGA forwarding ignores windows and ISA setting; off after reset.
// - Diagnostic internal reset sets bit 6 and clears every other bit.
package bcr_pkg;
    // Configuration dword holding interrupt line, pin and bridge control
    localparam logic [5:0]  BCR_DW_INTR_CTRL   = 6'h0f;
    localparam logic [7:0]  BCR_OFS_INTR_PIN   = 8'h3d;
    localparam logic [7:0]  BCR_OFS_BRIDGE_CTL = 8'h3e;
    localparam logic [7:0]  BCR_INTR_PIN_VAL   = 8'h00;
    localparam logic [15:0] BCR_CTRL_RESET     = 16'h0000;
    // Writable bits: 11,10,9,8,6,5,3,2,1,0
    localparam logic [15:0] BCR_CTRL_WR_MASK   = 16'h0f6f;
    // Field positions
    localparam int BCR_B_DISC_SERR = 11;
    localparam int BCR_B_DISC_STS  = 10;
    localparam int BCR_B_SEC_SHORT = 9;
    localparam int BCR_B_PRI_SHORT = 8;
    localparam int BCR_B_SEC_RST   = 6;
    localparam int BCR_B_MA_MODE   = 5;
    localparam int BCR_B_VGA_EN    = 3;
    localparam int BCR_B_ISA_EN    = 2;
    localparam int BCR_B_SERR_EN   = 1;
    localparam int BCR_B_PERR_EN   = 0;
    // Discard timer lengths in PCI clocks
    localparam int BCR_DISC_LONG_CYC  = 32768;
    localparam int BCR_DISC_SHORT_CYC = 1024;
    localparam int BCR_DISC_W         = 15;
    // VGA decode ranges
    localparam logic [31:0] BCR_VGA_MEM_LO  = 32'h000a_0000;
    localparam logic [31:0] BCR_VGA_MEM_HI  = 32'h000b_ffff;
    localparam logic [31:0] BCR_VGA_IO1_LO  = 32'h0000_03b0;
    localparam logic [31:0] BCR_VGA_IO1_HI  = 32'h0000_03bb;
    localparam logic [31:0] BCR_VGA_IO2_LO  = 32'h0000_03c0;
    localparam logic [31:0] BCR_VGA_IO2_HI  = 32'h0000_03df;
    localparam logic [31:0] BCR_MA_READ_VAL = 32'hffff_ffff;

    typedef enum logic [1:0] {
        BCR_TMR_IDLE = 2'b01,
        BCR_TMR_RUN  = 2'b10
    } bcr_tmr_state_t;
endpackage

// File: logic/bcr_tmr_if.sv
// Link between the control logic and one discard timer
`timescale 1ns/10ps
`default_nettype none
interface bcr_tmr_if;
    logic start;
    logic stop;
    logic short_sel;
    logic expired;
    modport ctrl  (output start, output stop, output short_sel, input expired);
    modport timer (input start, input stop, input short_sel, output expired);
endinterface
`default_nettype wire

// File: logic/bcr_discard_timer.sv
// Delayed completion discard timer
`timescale 1ns/10ps
`default_nettype none
module bcr_discard_timer
    import bcr_pkg::*;
#(
    parameter int LONG_CYCLES = bcr_pkg::BCR_DISC_LONG_CYC
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Control side
    bcr_tmr_if.timer  tif
);
    import bcr_pkg::*;

    localparam logic [BCR_DISC_W-1:0] LONG_LAST  = BCR_DISC_W'(LONG_CYCLES - 1);
    localparam logic [BCR_DISC_W-1:0] SHORT_LAST = BCR_DISC_W'(BCR_DISC_SHORT_CYC - 1);

    bcr_tmr_state_t          state_q, state_d;
    logic [BCR_DISC_W-1:0]   count_q, count_d;
    logic                    exp_q, exp_d;
    logic [BCR_DISC_W-1:0]   last;

    always_comb begin
        last    = tif.short_sel ? SHORT_LAST : LONG_LAST;
        state_d = state_q;
        count_d = count_q;
        exp_d   = 1'b0;
        case (state_q)
            BCR_TMR_IDLE: begin
                if (tif.start) begin
                    state_d = BCR_TMR_RUN;
                    count_d = '0;
                end
            end
            BCR_TMR_RUN: begin
                if (tif.stop) begin
                    state_d = BCR_TMR_IDLE;
                end else if (count_q >= last) begin
                    // Expiry discards the waiting completion
                    state_d = BCR_TMR_IDLE;
                    exp_d   = 1'b1;
                end else begin
                    count_d = count_q + 1'b1;
                end
            end
            default: begin
                state_d = BCR_TMR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= BCR_TMR_IDLE;
            count_q <= '0;
            exp_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            exp_q   <= exp_d;
        end
    end

    assign tif.expired = exp_q;
endmodule
`default_nettype wire

// File: dv/bcr_assertions.sv
// Port-level checks for the bridge control block
`timescale 1ns/10ps
`default_nettype none
module bcr_assertions (
    // Clock, reset and configuration access
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        cfg_rd,
    input wire logic        cfg_wr,
    input wire logic [5:0]  cfg_dword,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    // Events and their results
    input wire logic        diag_reset_req,
    input wire logic        sec_bus_reset_out,
    input wire logic        ma_event,
    input wire logic        ma_is_read,
    input wire logic        ma_posted_done,
    input wire logic        ma_return_ones,
    input wire logic [31:0] ma_read_data,
    input wire logic        ma_target_abort,
    input wire logic        primary_system_error_out,
    input wire logic        pri_cpl_discard
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_pin_reads_zero: assert property (cfg_rd && cfg_dword == 6'h0f |=> cfg_rdata[15:8] == 8'h00)
        else $error("interrupt pin byte not zero");
    a_rsvd_read_zero: assert property (cfg_rd |=> {cfg_rdata[31:28], cfg_rdata[23], cfg_rdata[20]} == 6'h00)
        else $error("reserved control bits not zero");
    a_sec_reset_follow: assert property (cfg_wr && cfg_dword == 6'h0f && cfg_be[2]
        |=> sec_bus_reset_out == $past(cfg_wdata[22]))
        else $error("secondary reset does not follow bit 6");
    a_diag_sets_reset: assert property (diag_reset_req |=> sec_bus_reset_out)
        else $error("internal reset left secondary reset low");
    a_ma_read_ones: assert property (ma_return_ones
        |-> ma_read_data == 32'hffff_ffff && $past(ma_event && ma_is_read))
        else $error("all ones return without a read abort");
    a_ma_write_quiet: assert property (ma_event && !ma_is_read |=> !ma_return_ones)
        else $error("write abort returned read data");
    a_ma_target_abort: assert property (ma_target_abort |-> $past(ma_event && !ma_posted_done))
        else $error("target abort without pending abort");
    a_serr_has_cause: assert property (primary_system_error_out
        |-> $past(pri_cpl_discard) || $past(ma_event && ma_posted_done))
        else $error("system error without cause");
endmodule
bind bcr_bridge_control bcr_assertions u_chk (.*);
`default_nettype wire

// File: dv/bcr_agent_model.sv
// Far-side masters: completion ready, then an optional repeat
`timescale 1ns/10ps
`default_nettype none
module bcr_agent_model (
    // Clock, reset and bench command
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [1:0]  go,
    input  wire logic [11:0] rep_after,
    // Toward the bridge
    output logic             pri_cpl_ready,
    output logic             sec_cpl_ready,
    output logic             pri_repeat,
    output logic             sec_repeat
);
    logic [11:0] cnt_q;
    logic        sec_q;
    // Zero count: the master never returns, so the bridge has to discard
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            {sec_cpl_ready, pri_cpl_ready, pri_repeat, sec_repeat, sec_q, cnt_q} <= '0;
        else begin
            {sec_cpl_ready, pri_cpl_ready} <= go;
            sec_q <= (go != 2'b00) ? go[1] : sec_q;
            cnt_q <= (go != 2'b00) ? rep_after : cnt_q - {11'h0, cnt_q != 12'h0};
            {sec_repeat, pri_repeat} <= {2{cnt_q == 12'h001}} & {sec_q, !sec_q};
        end
    end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the bridge control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import bcr_pkg::*;
    localparam int LONG = 64;
    logic        clock, rst, cfg_rd, cfg_wr, cfg_hit, diag_reset_req, cmd_serr_en;
    logic [5:0]  cfg_dword;
    logic [3:0]  cfg_be;
    logic [1:0]  go;
    logic [11:0] rep_after;
    logic [31:0] cfg_wdata, cfg_rdata, ma_read_data, fwd_addr, rd;
    logic        pri_cpl_ready, pri_repeat, sec_cpl_ready, sec_repeat, pri_cpl_discard;
    logic        sec_cpl_discard, ma_event, ma_is_read, ma_posted_done, ma_return_ones;
    logic        ma_discard_write, ma_target_abort, primary_system_error_out;
    logic        sec_bus_reset_out, fwd_valid, fwd_from_primary, fwd_is_io;
    logic        vga_fwd_claim, vga_fwd_block, isa_en, sec_serr_fwd_en, sec_perr_en;
    int          failures = 0, total_checks = 0, cyc = 0;
    bcr_bridge_control #(.DISC_LONG_CYCLES(LONG)) u_dut (.*);
    bcr_agent_model u_agent (.*);
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // Whole run is near 3400 cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cwr(input logic [5:0] dw, input logic [15:0] v);
        @(posedge clock);
        {cfg_wr, cfg_dword, cfg_be, cfg_wdata} <= {1'b1, dw, 4'hc, v, 16'h0000};
        @(posedge clock);
        cfg_wr <= 1'b0;
    endtask
    task automatic crd(input logic [5:0] dw);
        @(posedge clock);
        {cfg_rd, cfg_dword} <= {1'b1, dw};
        @(posedge clock);
        cfg_rd <= 1'b0;
        #1 rd = cfg_rdata;
    endtask
    task automatic disc(input logic [1:0] g, input logic [11:0] rep, input int exp, input logic s);
        int n;
        @(posedge clock);
        {go, rep_after} <= {g, rep};
        @(posedge clock);
        go <= 2'b00;
        // Loop starts at the edge that takes the completion
        for (n = 0; n < 1100; n++) begin
            @(posedge clock);
            #1;
            if ({sec_cpl_discard, pri_cpl_discard} === g) break;
        end
        chk("discard delay", n, exp);
        // System error is registered one cycle behind the discard pulse
        @(posedge clock);
        #1;
        chk("serr at discard", primary_system_error_out, s);
    endtask
    task automatic t_regs();
        crd(6'h0f);
        chk("reset value", rd, 32'h0);
        chk("dword hit", cfg_hit, 1'b1);
        cwr(6'h0f, 16'hffff);
        cwr(6'h10, 16'h0000);
        crd(6'h0f);
        chk("all ones written", rd, 32'h0b6f_0000);
        chk("control outputs", {sec_bus_reset_out, isa_en, sec_serr_fwd_en, sec_perr_en}, 4'hf);
        crd(6'h10);
        chk("unmapped dword", rd, 32'h0);
        @(posedge clock);
        diag_reset_req <= 1'b1;
        @(posedge clock);
        diag_reset_req <= 1'b0;
        crd(6'h0f);
        chk("internal reset", rd, 32'h0040_0000);
        cwr(6'h0f, 16'h0000);
        crd(6'h0f);
        chk("reset released", sec_bus_reset_out, 1'b0);
        $display("test regs done");
    endtask
    task automatic t_timer();
        cwr(6'h0f, 16'h0900);
        disc(2'b01, 12'h000, 1024, 1'b1);
        cwr(6'h0f, 16'h0100);
        crd(6'h0f);
        chk("status kept", rd[31:16], 16'h0500);
        cwr(6'h0f, 16'h0500);
        crd(6'h0f);
        chk("status cleared", rd[31:16], 16'h0100);
        disc(2'b01, 12'h00a, 1100, 1'b0);
        disc(2'b10, 12'h000, LONG, 1'b0);
        crd(6'h0f);
        chk("sec expiry status", rd[31:16], 16'h0500);
        cwr(6'h0f, 16'h0200);
        disc(2'b10, 12'h000, 1024, 1'b0);
        disc(2'b01, 12'h000, LONG, 1'b0);
        $display("test timer done");
    endtask
    task automatic t_ma();
        // Mode, SERR enable, read, done; then ones, discard, target abort, serr
        logic [7:0] c [5] = '{8'h28, 8'h44, 8'he2, 8'hd1, 8'h90};
        foreach (c[i]) begin
            cwr(6'h0f, {10'h000, c[i][7], 5'h00});
            {cmd_serr_en, ma_event, ma_is_read, ma_posted_done} <= {c[i][6], 1'b1, c[i][5:4]};
            @(posedge clock);
            ma_event <= 1'b0;
            #1 chk("abort result", {ma_return_ones, ma_discard_write, ma_target_abort,
                primary_system_error_out}, c[i][3:0]);
            chk("abort read data", ma_read_data, {32{c[i][3]}});
        end
        $display("test abort done");
    endtask
    task automatic t_vga();
        // Enable, primary, io; claim and block; address
        logic [39:0] v [12] = '{40'h40_000a0000, 40'hc2_000a0000, 40'hc2_000bffff,
            40'hc0_000c0000, 40'hc0_0009ffff, 40'he2_000003bb, 40'he0_000003bc,
            40'he2_000003c0, 40'he2_000003df, 40'he0_000003e0, 40'h81_000a0000,
            40'ha1_000003b0};
        foreach (v[i]) begin
            cwr(6'h0f, {12'h000, v[i][39], 3'h0});
            {fwd_valid, fwd_from_primary, fwd_is_io, fwd_addr} <= {1'b1, v[i][38:37], v[i][31:0]};
            @(posedge clock);
            fwd_valid <= 1'b0;
            #1 chk("vga decode", {vga_fwd_claim, vga_fwd_block}, v[i][33:32]);
        end
        $display("test vga done");
    endtask
    initial begin
        {cfg_rd, cfg_wr, cfg_dword, cfg_be, cfg_wdata, diag_reset_req, cmd_serr_en} = '0;
        {ma_event, ma_is_read, ma_posted_done, fwd_valid, fwd_from_primary} = '0;
        {fwd_is_io, fwd_addr, go, rep_after} = '0;
        rst = 1'b1;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_timer();
        t_ma();
        t_vga();
        end_of_test();
    end
endmodule
`default_nettype wire
